// [csf_pkg.sv]
// shared constants and types for the current sink fault interrupt block
package csf_pkg;

	localparam int  CSF_ADDR_W       = 8;
	localparam int  CSF_DATA_W       = 16;
	localparam int  CSF_NUM_PINS     = 3;

	localparam logic [7:0]  CSF_STATUS_OFS   = 8'h1a;
	localparam logic [7:0]  CSF_MASK_OFS     = 8'h22;

	localparam int  CSF_SINK_A_BIT   = 13;
	localparam int  CSF_SINK_B_BIT   = 12;

	localparam logic [15:0] CSF_STATUS_RESET = 16'h0000;
	localparam logic [15:0] CSF_MASK_RESET   = 16'h0000;
	localparam logic [15:0] CSF_SINK_BITS    = 16'h3000;
	localparam logic [15:0] CSF_RDATA_RESET  = 16'h0000;

	localparam int  CSF_PIN_LED_C    = 0;
	localparam int  CSF_PIN_LED_D    = 1;
	localparam int  CSF_PIN_LED_E    = 2;
	localparam int  CSF_PIN_WALL_FET = 2;

	localparam logic [2:0]  CSF_PIN_RESET    = 3'h0;

	typedef enum logic [1:0]
	{
		CSF_PF_GPIO,
		CSF_PF_LED,
		CSF_PF_WALL_FET,
		CSF_PF_OTHER
	} csf_pin_func_t;

endpackage : csf_pkg

// [csf_sink_fault_irq.sv]
// current sink fault flags, mask, sink interrupt and led / wall fet pin muxing
//
// What this block does
// - one sink interrupt built from two faults
// - rising loss-of-regulation edge sets sink flag
// - status read clears returned flags, but an edge in the read cycle sets its flag again
// - set mask bit blocks matching flag
// - mask bits reset to zero, unmasked
// - led outputs on general-purpose pins 10-12
// - led mode hides other pin functions
// - wall fet gate on pin 12
`timescale 1ns/1ps

module csf_sink_fault_irq
	import csf_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	input  wire logic [CSF_ADDR_W-1:0]  reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [CSF_DATA_W-1:0]  reg_wdata,
	output logic      [CSF_DATA_W-1:0]  reg_rdata,
	input  wire logic                   sink_a_reg_lost,
	input  wire logic                   sink_b_reg_lost,
	output logic                        sink_irq,
	input  wire csf_pin_func_t          pin_func [CSF_NUM_PINS],
	input  wire logic [CSF_NUM_PINS-1:0] led_on,
	input  wire logic                   wall_fet_on,
	input  wire logic [CSF_NUM_PINS-1:0] gpio_do,
	input  wire logic [CSF_NUM_PINS-1:0] gpio_oe,
	input  wire logic [CSF_NUM_PINS-1:0] alt_do,
	input  wire logic [CSF_NUM_PINS-1:0] alt_oe,
	input  wire logic [CSF_NUM_PINS-1:0] pin_in,
	output logic      [CSF_NUM_PINS-1:0] pin_out,
	output logic      [CSF_NUM_PINS-1:0] pin_oe,
	output logic      [CSF_NUM_PINS-1:0] gpio_di,
	output logic      [CSF_NUM_PINS-1:0] alt_di
);

	// returns {oe, out} for one pin; wall fet only exists on pin 12
	function automatic logic [1:0] csf_drive(
		input csf_pin_func_t f,
		input logic          is_fet_pin,
		input logic          led,
		input logic          fet,
		input logic          gdo,
		input logic          goe,
		input logic          ado,
		input logic          aoe
	);
		logic [1:0] r;
		r = 2'h0;
		case (f)
			CSF_PF_GPIO:     r = {goe, gdo};
			CSF_PF_LED:      r = {led, 1'b0};
			CSF_PF_WALL_FET: r = is_fet_pin ? {1'b1, fet} : 2'h0;
			CSF_PF_OTHER:    r = {aoe, ado};
			default:         r = 2'h0;
		endcase
		return r;
	endfunction : csf_drive

	logic [1:0]            fault_sync1_reg;
	logic [1:0]            fault_sync2_reg;
	logic [1:0]            fault_prev_reg;
	logic [1:0]            flag_reg;
	logic [1:0]            flag_next;
	logic [1:0]            mask_reg;
	logic [1:0]            mask_next;
	logic                  irq_reg;
	logic [CSF_DATA_W-1:0] rdata_reg;
	logic [CSF_DATA_W-1:0] rdata_next;
	logic [CSF_NUM_PINS-1:0] pin_sync1_reg;
	logic [CSF_NUM_PINS-1:0] pin_sync2_reg;
	logic [CSF_NUM_PINS-1:0] pin_out_reg;
	logic [CSF_NUM_PINS-1:0] pin_oe_reg;
	logic [CSF_NUM_PINS-1:0] gpio_di_reg;
	logic [CSF_NUM_PINS-1:0] alt_di_reg;
	logic [CSF_NUM_PINS-1:0] pin_out_next;
	logic [CSF_NUM_PINS-1:0] pin_oe_next;
	logic [CSF_NUM_PINS-1:0] gpio_di_next;
	logic [CSF_NUM_PINS-1:0] alt_di_next;

	wire        sel_status = (reg_addr == CSF_STATUS_OFS);
	wire        sel_mask   = (reg_addr == CSF_MASK_OFS);
	wire        rd_status  = reg_rd && sel_status;
	wire        wr_mask    = reg_wr && sel_mask;
	wire [1:0]  fault_edge = fault_sync2_reg & ~fault_prev_reg;
	wire [15:0] status_view = {2'h0, flag_reg, 12'h000};
	wire [15:0] mask_view   = {2'h0, mask_reg, 12'h000};

	// index 1 is sink a (bit 13), index 0 is sink b (bit 12)
	assign flag_next = fault_edge | (rd_status ? 2'h0 : flag_reg);
	assign mask_next = wr_mask ? reg_wdata[CSF_SINK_A_BIT:CSF_SINK_B_BIT] : mask_reg;

	assign rdata_next = !reg_rd    ? rdata_reg   :
	                    sel_status ? status_view :
	                    sel_mask   ? mask_view   :
	                                 CSF_RDATA_RESET;

	// the comparators are analog, so both fault levels are synchronised first
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			fault_sync1_reg <= 2'h0;
			fault_sync2_reg <= 2'h0;
			fault_prev_reg  <= 2'h0;
		end
		else
		begin
			fault_sync1_reg <= {sink_a_reg_lost, sink_b_reg_lost};
			fault_sync2_reg <= fault_sync1_reg;
			fault_prev_reg  <= fault_sync2_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			flag_reg  <= CSF_STATUS_RESET[CSF_SINK_A_BIT:CSF_SINK_B_BIT];
			mask_reg  <= CSF_MASK_RESET[CSF_SINK_A_BIT:CSF_SINK_B_BIT];
			rdata_reg <= CSF_RDATA_RESET;
		end
		else
		begin
			flag_reg  <= flag_next;
			mask_reg  <= mask_next;
			rdata_reg <= rdata_next;
		end
	end

	// registered so the output is glitch free; lags the flags by one cycle
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(flag_reg & ~mask_reg);
	end

	genvar gi;
	generate
		for (gi = 0; gi < CSF_NUM_PINS; gi++)
		begin : g_pin
			wire [1:0] drv = csf_drive(pin_func[gi], (gi == CSF_PIN_WALL_FET),
				led_on[gi], wall_fet_on, gpio_do[gi], gpio_oe[gi],
				alt_do[gi], alt_oe[gi]);
			assign pin_oe_next[gi]  = drv[1];
			assign pin_out_next[gi] = drv[0];
			// led mode claims the pin, so no other function sees its level
			assign gpio_di_next[gi] = (pin_func[gi] == CSF_PF_GPIO)
				&& pin_sync2_reg[gi];
			assign alt_di_next[gi]  = (pin_func[gi] == CSF_PF_OTHER)
				&& pin_sync2_reg[gi];
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_sync1_reg <= CSF_PIN_RESET;
			pin_sync2_reg <= CSF_PIN_RESET;
			pin_out_reg   <= CSF_PIN_RESET;
			pin_oe_reg    <= CSF_PIN_RESET;
			gpio_di_reg   <= CSF_PIN_RESET;
			alt_di_reg    <= CSF_PIN_RESET;
		end
		else
		begin
			pin_sync1_reg <= pin_in;
			pin_sync2_reg <= pin_sync1_reg;
			pin_out_reg   <= pin_out_next;
			pin_oe_reg    <= pin_oe_next;
			gpio_di_reg   <= gpio_di_next;
			alt_di_reg    <= alt_di_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign sink_irq  = irq_reg;
	assign pin_out   = pin_out_reg;
	assign pin_oe    = pin_oe_reg;
	assign gpio_di   = gpio_di_reg;
	assign alt_di    = alt_di_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_edge_sets_a: assert property (
		fault_sync2_reg[1] && !fault_prev_reg[1] |=> flag_reg[1] ##1 1'b1)
		else $error("sink a edge did not set its flag");

	a_edge_sets_b: assert property (
		$rose(fault_sync2_reg[0]) |=> flag_reg[0])
		else $error("sink b edge did not set its flag");

	a_read_clears: assert property (
		rd_status && !fault_edge[1] |=> !flag_reg[1])
		else $error("status read did not clear sink a flag");

	a_flag_no_self_set: assert property (
		!flag_reg[0] && !fault_edge[0] |=> !flag_reg[0])
		else $error("sink b flag set without an edge");

	a_read_returns_flags: assert property (
		rd_status |=> reg_rdata == {2'h0, $past(flag_reg), 12'h000})
		else $error("status read returned wrong value");

	a_irq_follows: assert property (
		|(flag_reg & ~mask_reg) |=> sink_irq)
		else $error("unmasked flag did not raise interrupt");

	a_irq_drops: assert property (
		!(|(flag_reg & ~mask_reg)) |=> !sink_irq)
		else $error("interrupt stayed high with no unmasked flag");

	a_mask_blocks: assert property (
		(mask_reg == 2'h3) && !wr_mask |=> !sink_irq)
		else $error("masked flags still raised interrupt");

	a_mask_write: assert property (
		!wr_mask |=> $stable(mask_reg))
		else $error("mask changed without a write");

	a_led_drive: assert property (
		pin_func[0] == CSF_PF_LED |=> !pin_out[0] && pin_oe[0] == $past(led_on[0]))
		else $error("led c not driven open drain");

	a_led_hides_in: assert property (
		pin_func[1] == CSF_PF_LED |=> !gpio_di[1] && !alt_di[1])
		else $error("led pin leaked its input");

	a_fet_pin12: assert property (
		pin_func[2] == CSF_PF_WALL_FET |=> pin_oe[2] && pin_out[2] == $past(wall_fet_on))
		else $error("wall fet gate not on pin 12");

	a_fet_not_pin10: assert property (
		pin_func[0] == CSF_PF_WALL_FET |=> !pin_oe[0])
		else $error("wall fet drove a wrong pin");

	c_fault_irq: cover property (fault_edge[1] ##2 sink_irq);
	c_set_on_read: cover property (rd_status && fault_edge[0]);
	c_masked_fault: cover property (mask_reg[1] && fault_edge[1]);
	c_fet_active: cover property (pin_func[2] == CSF_PF_WALL_FET && wall_fet_on);

endmodule : csf_sink_fault_irq

// [csf_sink_fault_irq_test.sv]
// self-checking bench for the current sink fault interrupt block
`timescale 1ns/1ps

module csf_sink_fault_irq_test
	import csf_pkg::*;
;
	logic                    clk_sys;
	logic                    rstn;
	logic [CSF_ADDR_W-1:0]   reg_addr;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [CSF_DATA_W-1:0]   reg_wdata;
	logic [CSF_DATA_W-1:0]   reg_rdata;
	logic                    sink_a_reg_lost;
	logic                    sink_b_reg_lost;
	logic                    sink_irq;
	csf_pin_func_t           pin_func [CSF_NUM_PINS];
	logic [CSF_NUM_PINS-1:0] led_on;
	logic                    wall_fet_on;
	logic [CSF_NUM_PINS-1:0] gpio_do;
	logic [CSF_NUM_PINS-1:0] gpio_oe;
	logic [CSF_NUM_PINS-1:0] alt_do;
	logic [CSF_NUM_PINS-1:0] alt_oe;
	logic [CSF_NUM_PINS-1:0] pin_in;
	logic [CSF_NUM_PINS-1:0] pin_out;
	logic [CSF_NUM_PINS-1:0] pin_oe;
	logic [CSF_NUM_PINS-1:0] gpio_di;
	logic [CSF_NUM_PINS-1:0] alt_di;
	int                      n_errors;
	int                      comparisons;
	int                      cycles = 0;

	csf_sink_fault_irq csf_sink_fault_irq_inst (.clk_sys(clk_sys), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sink_a_reg_lost(sink_a_reg_lost),
		.sink_b_reg_lost(sink_b_reg_lost), .sink_irq(sink_irq), .pin_func(pin_func),
		.led_on(led_on), .wall_fet_on(wall_fet_on), .gpio_do(gpio_do), .gpio_oe(gpio_oe),
		.alt_do(alt_do), .alt_oe(alt_oe), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .gpio_di(gpio_di), .alt_di(alt_di));

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task results;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// read data lands on the read edge itself, sampled at the second falling edge after it
	task rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		@(negedge clk_sys);
		check(reg_rdata, exp);
	endtask : rd_chk

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : wr

	// both faults drop for a few cycles so the synchroniser sees a clean new edge
	task pulse_both;
		@(negedge clk_sys);
		sink_a_reg_lost = 1'b0;
		sink_b_reg_lost = 1'b0;
		repeat (3) @(negedge clk_sys);
		sink_a_reg_lost = 1'b1;
		sink_b_reg_lost = 1'b1;
		repeat (6) @(negedge clk_sys);
	endtask : pulse_both

	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			n_errors++;
			results();
		end
	end

	initial
	begin
		{rstn, reg_addr, reg_wr, reg_rd, reg_wdata, sink_a_reg_lost, sink_b_reg_lost} = '0;
		{led_on, wall_fet_on, gpio_do, gpio_oe, alt_do, alt_oe, pin_in} = '0;
		pin_func = '{CSF_PF_GPIO, CSF_PF_GPIO, CSF_PF_GPIO};
		{n_errors, comparisons} = '0;
		repeat (10) @(negedge clk_sys);
		rstn = 1'b1;
		rd_chk(CSF_MASK_OFS, 16'h0000);
		rd_chk(CSF_STATUS_OFS, 16'h0000);
		rd_chk(8'h00, 16'h0000);
		sink_a_reg_lost = 1'b1;
		repeat (6) @(negedge clk_sys);
		check(16'(sink_irq), 16'h0001);
		rd_chk(CSF_STATUS_OFS, 16'h2000);
		repeat (2) @(negedge clk_sys);
		check(16'(sink_irq), 16'h0000);
		rd_chk(CSF_STATUS_OFS, 16'h0000);
		sink_b_reg_lost = 1'b1;
		repeat (6) @(negedge clk_sys);
		rd_chk(CSF_STATUS_OFS, 16'h1000);
		wr(CSF_MASK_OFS, 16'hffff);
		rd_chk(CSF_MASK_OFS, CSF_SINK_BITS);
		pulse_both();
		check(16'(sink_irq), 16'h0000);
		wr(CSF_MASK_OFS, 16'h2000);
		repeat (2) @(negedge clk_sys);
		check(16'(sink_irq), 16'h0001);
		rd_chk(CSF_STATUS_OFS, 16'h3000);
		// mid-run reset with faults low, so no edge follows the release
		rstn = 1'b0;
		{sink_a_reg_lost, sink_b_reg_lost} = 2'h0;
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		rd_chk(CSF_MASK_OFS, 16'h0000);
		check(16'(sink_irq), 16'h0000);
		@(negedge clk_sys);
		pin_func = '{CSF_PF_LED, CSF_PF_GPIO, CSF_PF_WALL_FET};
		{led_on, wall_fet_on, gpio_do, gpio_oe, pin_in} = {3'h1, 1'b1, 3'h7, 3'h7, 3'h7};
		repeat (4) @(negedge clk_sys);
		check(16'(pin_oe), 16'h0007);
		check(16'(pin_out), 16'h0006);
		check(16'(gpio_di), 16'h0002);
		wall_fet_on = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(16'(pin_out), 16'h0002);
		// wall fet gate is only offered on pin 12, so pin 10 must stay undriven
		pin_func = '{CSF_PF_WALL_FET, CSF_PF_OTHER, CSF_PF_LED};
		{led_on, alt_do, alt_oe} = {3'h0, 3'h0, 3'h7};
		repeat (4) @(negedge clk_sys);
		check(16'(pin_oe), 16'h0002);
		check(16'(alt_di), 16'h0002);
		results();
	end

endmodule : csf_sink_fault_irq_test
